//--- core/dio_channel.sv
// Purpose: one digital i/o channel with wishbone registers
// Assumes: line input asynchronous to clk_i
// Notes: pulse, delay and failsafe timing counts a 100 ms tick
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - direction bit picks input or output, input default
// - invert complements reported input status
// - latch remembers chosen transition until cleared
// - alarm raised on chosen input transition
// - auto clear drops alarm when input returns
// - manual clear holds alarm until clear command
// - event pulse on raise and clear, kind flagged
// - drive type selects sink, source or both
// - manual mode follows activate, deactivate and failsafe action
// - pulse mode alternates after activate
// - pulse continuous or counted sub-mode
// - each count is active then inactive phase
// - inactive phase lasts width times 100 ms
// - active phase lasts width times 100 ms
// - inactive-to-active delay then goes active
// - active-to-inactive delay then goes inactive
// - delay equals value times 100 ms
// - failsafe applies none, activate or deactivate
// - failsafe timer fires after idle seconds
module dio_channel
   import dio_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic line_i,
   output logic line_o,
   output logic line_oe_o,
   output alarm_evt_t evt_o,
   output logic alarm_o
);
   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00, SQ_ACT = 2'b01, SQ_INACT = 2'b10, SQ_DLY = 2'b11
   } seq_t;
   logic [15:0] ctrl_r;
   logic [15:0] actw_r, inaw_r, dly_r, cnt_r, fs_sec_r;
   logic [31:0] div_r;
   logic [31:0] div_cnt_r;
   logic tick;
   logic sync1_r, sync2_r, stat_prev_r;
   logic status;
   logic latched_r, alarm_r;
   logic out_r;
   seq_t seq_r;
   logic [15:0] tmr_r, left_r;
   logic [15:0] fs_cnt_r;
   logic [3:0] fs_sub_r;
   logic fs_fired_r;
   logic wr, rd_ok, cmd_act, cmd_deact, cmd_aclr, cmd_lclr, activity;
   logic fire;
   logic is_out;
   latch_t lat_m;
   trig_t trg_m;
   drive_t drv_m;
   omode_t om_m;
   fsact_t fsa_m;

   assign lat_m = latch_t'(ctrl_r[C_LAT +: 2]);
   assign trg_m = trig_t'(ctrl_r[C_TRG +: 2]);
   assign drv_m = drive_t'(ctrl_r[C_DRV +: 2]);
   assign om_m = omode_t'(ctrl_r[C_OMD +: 2]);
   assign fsa_m = fsact_t'(ctrl_r[C_FSA +: 2]);
   assign is_out = ctrl_r[C_DIR];

   // wishbone slave, one wait state, ack drops after one cycle
   assign wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
   assign cmd_act = wr && adr_i == A_CMD && dat_i[K_ACT];
   assign cmd_deact = wr && adr_i == A_CMD && dat_i[K_DEACT];
   assign cmd_aclr = wr && adr_i == A_CMD && dat_i[K_ACLR];
   assign cmd_lclr = wr && adr_i == A_CMD && dat_i[K_LCLR];
   assign activity = cyc_i & stb_i & ~ack_o;
   assign rd_ok = 1'b1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= cyc_i & stb_i & ~ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= CTRL_DEF;
         actw_r <= WIDTH_DEF;
         inaw_r <= WIDTH_DEF;
         dly_r <= WIDTH_DEF;
         cnt_r <= COUNT_DEF;
         fs_sec_r <= FS_SEC_DEF;
         div_r <= 32'(TICK_DIV);
      end else if (ce_i && wr) begin
         case (adr_i)
            A_CTRL: ctrl_r <= dat_i[15:0];
            A_ACTW: actw_r <= dat_i[15:0];
            A_INAW: inaw_r <= dat_i[15:0];
            A_DLY: dly_r <= dat_i[15:0];
            A_CNT: cnt_r <= dat_i[15:0];
            A_FS: fs_sec_r <= dat_i[15:0];
            A_DIV: div_r <= dat_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (ce_i && cyc_i && stb_i && !we_i && !ack_o && rd_ok) begin
         case (adr_i)
            A_CTRL: dat_o <= {16'h0000, ctrl_r};
            A_ACTW: dat_o <= {16'h0000, actw_r};
            A_INAW: dat_o <= {16'h0000, inaw_r};
            A_DLY: dat_o <= {16'h0000, dly_r};
            A_CNT: dat_o <= {16'h0000, cnt_r};
            A_FS: dat_o <= {16'h0000, fs_sec_r};
            A_DIV: dat_o <= div_r;
            A_STAT: dat_o <= {25'h0000000, fs_fired_r, seq_r, out_r,
                              alarm_r, latched_r, status};
            default: dat_o <= 32'h00000000;
         endcase
      end
   end

   // 100 ms tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt_r <= 32'h00000000;
      end else if (ce_i) begin
         if (div_cnt_r + 32'h00000001 >= div_r) begin
            div_cnt_r <= 32'h00000000;
         end else begin
            div_cnt_r <= div_cnt_r + 32'h00000001;
         end
      end
   end
   assign tick = ce_i && (div_cnt_r + 32'h00000001 >= div_r);

   // input side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         stat_prev_r <= 1'b0;
      end else if (ce_i) begin
         sync1_r <= line_i;
         sync2_r <= sync1_r;
         stat_prev_r <= status;
      end
   end
   assign status = sync2_r ^ ctrl_r[C_INV];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latched_r <= 1'b0;
      end else if (ce_i) begin
         if ((lat_m == LAT_RISE && status && !stat_prev_r) ||
             (lat_m == LAT_FALL && !status && stat_prev_r)) begin
            latched_r <= 1'b1;
         end else if (cmd_lclr) begin
            latched_r <= 1'b0;
         end
      end
   end

   logic trig_edge, trig_back;
   assign trig_edge = (trg_m == TRG_INACT && !status && stat_prev_r) ||
                      (trg_m == TRG_ACT && status && !stat_prev_r);
   assign trig_back = (trg_m == TRG_INACT && status) ||
                      (trg_m == TRG_ACT && !status);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alarm_r <= 1'b0;
         evt_o <= '0;
      end else if (ce_i) begin
         evt_o <= '0;
         if (!alarm_r && trig_edge && !is_out) begin
            alarm_r <= 1'b1;
            evt_o <= '{valid: 1'b1, raised: 1'b1};
         end else if (alarm_r && ((ctrl_r[C_MAN] && cmd_aclr) ||
                    (!ctrl_r[C_MAN] && ctrl_r[C_AUTO] && trig_back))) begin
            alarm_r <= 1'b0;
            evt_o <= '{valid: 1'b1, raised: 1'b0};
         end
      end
   end
   assign alarm_o = alarm_r;

   // failsafe timer, seconds counted in ticks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fs_cnt_r <= 16'h0000;
         fs_sub_r <= 4'h0;
         fs_fired_r <= 1'b0;
      end else if (ce_i) begin
         if (!ctrl_r[C_FSEN] || activity) begin
            fs_cnt_r <= 16'h0000;
            fs_sub_r <= 4'h0;
            fs_fired_r <= 1'b0;
         end else if (tick && !fs_fired_r) begin
            if (fs_sub_r == 4'(SEC_TICKS - 1)) begin
               fs_sub_r <= 4'h0;
               fs_cnt_r <= fs_cnt_r + 16'h0001;
               fs_fired_r <= (fs_cnt_r + 16'h0001 >= fs_sec_r);
            end else begin
               fs_sub_r <= fs_sub_r + 4'h1;
            end
         end
      end
   end
   assign fire = ce_i && tick && !fs_fired_r && ctrl_r[C_FSEN] &&
                 !activity && fs_sub_r == 4'(SEC_TICKS - 1) &&
                 fs_cnt_r + 16'h0001 >= fs_sec_r;

   // output sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_r <= 1'b0;
         seq_r <= SQ_IDLE;
         tmr_r <= 16'h0000;
         left_r <= 16'h0000;
      end else if (ce_i) begin
         if (cmd_act || cmd_deact) begin
            out_r <= cmd_act;
            seq_r <= SQ_IDLE;
            left_r <= cnt_r;
            tmr_r <= 16'h0000;
            if (om_m == OM_PULSE && cmd_act) begin
               seq_r <= SQ_ACT;
            end else if (om_m == OM_I2A && cmd_act) begin
               out_r <= 1'b0;
               seq_r <= SQ_DLY;
            end else if (om_m == OM_A2I && cmd_act) begin
               seq_r <= SQ_DLY;
            end
         end else if (fire && fsa_m != FSA_NONE) begin
            out_r <= (fsa_m == FSA_ACT);
            seq_r <= SQ_IDLE;
         end else if (tick) begin
            case (seq_r)
               SQ_ACT: begin
                  if (tmr_r + 16'h0001 >= actw_r) begin
                     tmr_r <= 16'h0000;
                     out_r <= 1'b0;
                     seq_r <= SQ_INACT;
                  end else begin
                     tmr_r <= tmr_r + 16'h0001;
                  end
               end
               SQ_INACT: begin
                  if (tmr_r + 16'h0001 >= inaw_r) begin
                     tmr_r <= 16'h0000;
                     if (ctrl_r[C_PCNT] && left_r <= 16'h0001) begin
                        seq_r <= SQ_IDLE;
                     end else begin
                        out_r <= 1'b1;
                        seq_r <= SQ_ACT;
                     end
                     left_r <= left_r - 16'h0001;
                  end else begin
                     tmr_r <= tmr_r + 16'h0001;
                  end
               end
               SQ_DLY: begin
                  if (tmr_r + 16'h0001 >= dly_r) begin
                     out_r <= (om_m == OM_I2A);
                     seq_r <= SQ_IDLE;
                  end else begin
                     tmr_r <= tmr_r + 16'h0001;
                  end
               end
               default: seq_r <= SQ_IDLE;
            endcase
         end
      end
   end

   // pin drive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_o <= 1'b0;
         line_oe_o <= 1'b0;
      end else if (ce_i) begin
         line_oe_o <= is_out && (drv_m == DRV_BOTH || out_r);
         line_o <= is_out && (drv_m != DRV_SINK) && out_r;
      end
   end

   chk_evt_raise: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !alarm_r && trig_edge && !is_out |=> evt_o.valid && evt_o.raised
      && alarm_r) else $error("alarm raise event missing");
   chk_evt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && alarm_r && !ctrl_r[C_MAN] && ctrl_r[C_AUTO] && trig_back
      |=> evt_o.valid && !evt_o.raised) else $error("clear event missing");
   chk_man_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_r[C_MAN] && alarm_r && !cmd_aclr |=> alarm_r)
      else $error("manual alarm dropped");
   chk_auto_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !ctrl_r[C_MAN] && ctrl_r[C_AUTO] && alarm_r && trig_back
      |=> !alarm_r) else $error("auto clear failed");
   chk_inv_stat: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> status == ($past(sync1_r) ^ ctrl_r[C_INV]))
      else $error("invert wrong");
   chk_cmd_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && cmd_deact |=> !out_r && seq_r == SQ_IDLE)
      else $error("deactivate not applied");
   chk_dly_start: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && cmd_act && om_m == OM_I2A |=> !out_r && seq_r == SQ_DLY)
      else $error("delay start wrong");
   chk_a2i_start: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && cmd_act && om_m == OM_A2I |=> out_r && seq_r == SQ_DLY)
      else $error("delay hold wrong");
   chk_sink_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && drv_m == DRV_SINK && is_out && !out_r |=> !line_oe_o)
      else $error("sink drives while inactive");
   chk_both_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && is_out && drv_m == DRV_BOTH |=> line_oe_o)
      else $error("both drive not driving");
   chk_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      latched_r && !cmd_lclr |=> latched_r)
      else $error("latch lost");
   chk_tick_once: assert property (@(posedge clk_i) disable iff (rst_i)
      tick && div_r > 32'h00000001 |=> !tick)
      else $error("tick longer than one cycle");
   chk_fs_act: assert property (@(posedge clk_i) disable iff (rst_i)
      fire && fsa_m == FSA_ACT && !cmd_act && !cmd_deact |=> out_r)
      else $error("failsafe activate missed");
   chk_fs_deact: assert property (@(posedge clk_i) disable iff (rst_i)
      fire && fsa_m == FSA_DEACT && !cmd_act && !cmd_deact |=> !out_r)
      else $error("failsafe deactivate missed");
endmodule

//--- core/dio_pkg.sv
// Purpose: constants and types for the digital i/o channel
// Assumes: 32-bit classic wishbone, 50 MHz clock
// Notes: register map word aligned
package dio_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int SEC_TICKS = 10;
   localparam logic [15:0] WIDTH_DEF = 16'h0001;
   localparam logic [15:0] COUNT_DEF = 16'h0001;
   localparam logic [15:0] FS_SEC_DEF = 16'h001E;
   localparam logic [15:0] CTRL_DEF = 16'h0040;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD = 8'h04;
   localparam logic [7:0] A_ACTW = 8'h08;
   localparam logic [7:0] A_INAW = 8'h0C;
   localparam logic [7:0] A_DLY = 8'h10;
   localparam logic [7:0] A_CNT = 8'h14;
   localparam logic [7:0] A_FS = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1C;
   localparam logic [7:0] A_DIV = 8'h20;
   localparam int C_DIR = 0;
   localparam int C_INV = 1;
   localparam int C_LAT = 2;
   localparam int C_TRG = 4;
   localparam int C_AUTO = 6;
   localparam int C_MAN = 7;
   localparam int C_DRV = 8;
   localparam int C_OMD = 10;
   localparam int C_PCNT = 12;
   localparam int C_FSA = 13;
   localparam int C_FSEN = 15;
   localparam int K_ACT = 0;
   localparam int K_DEACT = 1;
   localparam int K_ACLR = 2;
   localparam int K_LCLR = 3;
   localparam int K_KICK = 4;
   typedef enum logic [1:0] {
      LAT_NONE = 2'b00, LAT_RISE = 2'b01, LAT_FALL = 2'b10
   } latch_t;
   typedef enum logic [1:0] {
      TRG_OFF = 2'b00, TRG_INACT = 2'b01, TRG_ACT = 2'b10
   } trig_t;
   typedef enum logic [1:0] {
      DRV_SINK = 2'b00, DRV_SOURCE = 2'b01, DRV_BOTH = 2'b10
   } drive_t;
   typedef enum logic [1:0] {
      OM_MANUAL = 2'b00, OM_PULSE = 2'b01, OM_I2A = 2'b10, OM_A2I = 2'b11
   } omode_t;
   typedef enum logic [1:0] {
      FSA_NONE = 2'b00, FSA_ACT = 2'b01, FSA_DEACT = 2'b10
   } fsact_t;
   typedef struct packed {
      logic valid;
      logic raised;
   } alarm_evt_t;
   typedef struct packed {
      logic oe;
      logic level;
   } pin_drv_t;
endpackage

//--- verif/digital_io_channel_logic_bench.sv
// Purpose: self-checking bench for one digital i/o channel
// Assumes: tick divider set to 10 cycles, so one tick is 200 ns
// Notes: phase times allow one tick of slack at sequence start
`timescale 1ns/1ps
module digital_io_channel_logic_bench;
   import dio_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic sense = 1'b0;
   logic ce = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic ack_o, line_i, line_o, line_oe_o, alarm_o, pin;
   logic evt_up = 1'b0;
   alarm_evt_t evt_o;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int evt_n = 0;

   dio_channel #(.TICK_DIV(10)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o),
      .evt_o(evt_o), .alarm_o(alarm_o));
   field_model field (.sensor_i(sense), .line_o(line_o),
      .line_oe_o(line_oe_o), .line_i(line_i), .pin_o(pin));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task complete_run;
      $display("counts: %0d mismatches, %0d compares", bad_count,
         comparisons);
      if (bad_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // event monitor and hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (evt_o.valid === 1'b1) begin
         evt_n++;
         evt_up = evt_o.raised;
      end
      if (cycles == 40000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      while (ack_o !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) bad_count++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic meas(input int n, output int hi, output int up);
      logic p;
      hi = 0;
      up = 0;
      p = pin;
      repeat (n) begin
         @(posedge clk_i);
         if (pin === 1'b1) hi++;
         if (pin === 1'b1 && p !== 1'b1) up++;
         p = pin;
      end
   endtask

   task automatic t_reset;
      chk(line_oe_o, 0);
      rdc(A_CTRL, 32'hFFFF, 32'h0040);
      rdc(A_ACTW, 32'hFFFF, 32'h1);
      rdc(A_INAW, 32'hFFFF, 32'h1);
      rdc(A_DLY, 32'hFFFF, 32'h1);
      rdc(A_CNT, 32'hFFFF, 32'h1);
      rdc(A_FS, 32'hFFFF, 32'h1E);
      rdc(8'h24, 32'hFFFFFFFF, 32'h0);
      wr(A_DIV, 32'hA);
      $display("reset test done");
   endtask

   task automatic t_input;
      int n0;
      wr(A_CTRL, 32'h64);
      wr(A_CMD, 32'h8);
      n0 = evt_n;
      sense <= 1'b1;
      wt(8);
      rdc(A_STAT, 32'h7, 32'h7);
      chk(evt_n, n0 + 1);
      chk(evt_up, 1);
      sense <= 1'b0;
      wt(8);
      chk(alarm_o, 0);
      chk(evt_n, n0 + 2);
      chk(evt_up, 0);
      rdc(A_STAT, 32'h7, 32'h2);
      wr(A_CMD, 32'h8);
      rdc(A_STAT, 32'h2, 32'h0);
      wr(A_CTRL, 32'h5A);
      rdc(A_STAT, 32'h1, 32'h1);
      sense <= 1'b1;
      wt(8);
      sense <= 1'b0;
      wt(8);
      chk(alarm_o, 0);
      rdc(A_STAT, 32'h2, 32'h2);
      sense <= 1'b1;
      wt(8);
      chk(alarm_o, 1);
      wr(A_CTRL, 32'hE0);
      sense <= 1'b0;
      wt(8);
      chk(alarm_o, 1);
      wr(A_CMD, 32'h4);
      wt(2);
      chk(alarm_o, 0);
      sense <= 1'b0;
      $display("input test done");
   endtask

   task automatic t_drive;
      logic [1:0] on_t [3] = '{2'h2, 2'h3, 2'h3};
      logic [1:0] off_t [3] = '{2'h0, 2'h0, 2'h2};
      for (int d = 0; d < 3; d++) begin
         wr(A_CTRL, 32'h1 | (d << 8));
         wr(A_CMD, 32'h1);
         wt(40);
         chk({line_oe_o, line_o}, on_t[d]);
         wr(A_CMD, 32'h2);
         wt(2);
         chk({line_oe_o, line_o}, off_t[d]);
      end
      $display("drive test done");
   endtask

   task automatic t_pulse;
      int hi, up;
      wr(A_ACTW, 32'h2);
      wr(A_INAW, 32'h3);
      wr(A_CNT, 32'h2);
      wr(A_CTRL, 32'h1601);
      wr(A_CMD, 32'h1);
      meas(150, hi, up);
      chk(up, 2);
      chk(hi >= 28 && hi <= 40, 1);
      chk(pin, 0);
      wr(A_ACTW, 32'h1);
      wr(A_INAW, 32'h1);
      wr(A_CTRL, 32'h0601);
      wr(A_CMD, 32'h1);
      meas(100, hi, up);
      chk(up >= 4, 1);
      ce <= 1'b0;
      wt(1);
      meas(60, hi, up);
      chk(up, 0);
      chk(hi == 0 || hi == 60, 1);
      ce <= 1'b1;
      wr(A_CMD, 32'h2);
      meas(60, hi, up);
      chk(hi, 0);
      $display("pulse test done");
   endtask

   task automatic t_delay;
      wr(A_DLY, 32'h3);
      wr(A_CTRL, 32'h0A01);
      wr(A_CMD, 32'h1);
      wt(15);
      chk(pin, 0);
      wt(25);
      chk(pin, 1);
      wr(A_CTRL, 32'h0E01);
      wr(A_CMD, 32'h1);
      wt(15);
      chk(pin, 1);
      wt(25);
      chk(pin, 0);
      $display("delay test done");
   endtask

   task automatic t_fail;
      wr(A_FS, 32'h1);
      wr(A_CTRL, 32'hA201);
      wr(A_CMD, 32'h2);
      wt(80);
      chk(pin, 0);
      wt(50);
      chk(pin, 1);
      wr(A_CTRL, 32'hC201);
      wt(80);
      chk(pin, 1);
      wt(50);
      chk(pin, 0);
      $display("failsafe test done");
   endtask

   initial begin
      wt(16);
      rst_i <= 1'b0;
      t_reset();
      t_input();
      t_drive();
      t_pulse();
      t_delay();
      t_fail();
      complete_run();
   end
endmodule

//--- verif/field_model.sv
// Purpose: field sensor and actuator on one channel terminal
// Assumes: sensor level is set by the bench
// Notes: an undriven terminal shows the sensor, never the last drive
`timescale 1ns/1ps
module field_model (
   input wire logic sensor_i,
   input wire logic line_o,
   input wire logic line_oe_o,
   output logic line_i,
   output logic pin_o
);
   assign pin_o = line_oe_o ? line_o : sensor_i;
   assign line_i = pin_o;
endmodule
